// *** fsr_seq.sv ***
/*
 * Command sequencer: unique-ID read, security-region erase/program/read,
 * two-frame software reset, four-wire wrapped burst read.
 * Assumes the serial bus is slow against i_mclk (several clocks per half
 * period) and that main-array data answers o_arr_addr within two clocks.
 */
`default_nettype none

module fsr_seq
   import fsr_pkg::*;
#(
   parameter int ERASE_CYC = FSR_ERASE_CYC,
   parameter int PROG_CYC = FSR_PROG_CYC,
   parameter int RST_CYC = FSR_RST_CYC,
   parameter logic [127:0] UID = FSR_UID_DFLT
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic [3:0] i_dq,
   output logic [3:0] o_dq,
   output logic [3:0] o_dq_oe,
   input wire logic i_four_wire_command_mode,
   input wire logic i_write_latch_flag,
   input wire logic i_region1_lock_bit,
   input wire logic i_region2_lock_bit,
   input wire logic i_region3_lock_bit,
   input wire logic [7:0] i_arr_data,
   output logic [23:0] o_arr_addr,
   output logic o_busy_flag,
   output logic o_clr_write_latch,
   output logic o_soft_reset,
   output logic o_reset_recovery,
   output logic [7:0] o_read_param_field
);
   // ****************************************
   // pin sampling and edges
   // ****************************************
   logic [5:0] sy;
   logic s_cs_n;
   logic s_clk;
   logic [3:0] s_dq;
   logic clk_q_ff;
   logic cs_q_ff;
   logic rise;
   logic fall;
   logic f_start;
   logic f_end;
   logic quad;

   fsr_sync2 #(
      .WIDTH(6),
      .RST_VAL(6'h20)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_d({i_cs_n, i_sclk, i_dq}),
      .o_q(sy)
   );

   assign s_cs_n = sy[5];
   assign s_clk = sy[4];
   assign s_dq = sy[3:0];
   assign quad = i_four_wire_command_mode;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         clk_q_ff <= 1'b0;
         cs_q_ff <= 1'b1;
      end else begin
         clk_q_ff <= s_clk;
         cs_q_ff <= s_cs_n;
      end
   end

   assign rise = s_clk & ~clk_q_ff & ~s_cs_n;
   assign fall = ~s_clk & clk_q_ff & ~s_cs_n;
   assign f_start = cs_q_ff & ~s_cs_n;
   assign f_end = ~cs_q_ff & s_cs_n;

   // ****************************************
   // state and shared signals
   // ****************************************
   fsr_ser_e st_ff;
   fsr_ser_e cmd_next;
   fsr_op_e op_ff;
   logic [7:0] cmd_ff;
   logic [7:0] in_ff;
   logic [23:0] addr_ff;
   logic [23:0] rptr_ff;
   logic [5:0] cnt_ff;
   logic [3:0] dum_ff;
   logic [2:0] ocnt_ff;
   logic [7:0] osr_ff;
   logic [3:0] dq_ff;
   logic [3:0] oe_ff;
   logic got_ff;
   logic [7:0] pidx_ff;
   logic [7:0] pbuf [FSR_PAGE_BYTES];
   logic [FSR_PAGE_BYTES-1:0] pvalid_ff;
   logic busy_ff;
   logic rec_ff;
   logic armed_ff;
   logic clr_wel_ff;
   logic srst_ff;
   logic [7:0] param_ff;
   logic [23:0] tmr_ff;
   logic [10:0] widx_ff;
   logic [1:0] ors_ff;
   logic [1:0] opg_ff;
   logic [5:0] step;
   logic [5:0] nxt_cnt;
   logic [7:0] nxt_in;
   logic [23:0] nxt_addr;
   logic [7:0] src;
   logic [6:0] ubase;
   logic [5:0] wmask;
   logic [3:0] wrap_dum;
   logic [7:0] mem_rd;
   logic [2:0] lock_v;
   logic locked;
   logic ers_go;
   logic prg_go;
   logic rst_go;
   logic arm_hit;
   logic par_ld;
   logic wdone;
   logic [23:0] nxt_rptr;

   assign step = quad ? 6'h04 : 6'h01;
   assign nxt_cnt = cnt_ff + step;
   assign nxt_in = quad ? {in_ff[3:0], s_dq} : {in_ff[6:0], s_dq[0]};
   assign nxt_addr = quad ? {addr_ff[19:0], s_dq} : {addr_ff[22:0], s_dq[0]};

   // ****************************************
   // command decode
   // ****************************************
   // reset frames get through a busy array so a hung op can be aborted
   always_comb begin
      cmd_next = ST_IGN;
      if (rec_ff) begin
         cmd_next = ST_IGN;
      end else if (nxt_in == FSR_CMD_ARM || nxt_in == FSR_CMD_RST) begin
         cmd_next = ST_TAIL;
      end else if (!busy_ff) begin
         case (nxt_in)
            FSR_CMD_UID, FSR_CMD_READ, FSR_CMD_ERASE, FSR_CMD_PROG: begin
               cmd_next = ST_ADDR;
            end
            FSR_CMD_WRAP: begin
               cmd_next = quad ? ST_ADDR : ST_IGN;
            end
            FSR_CMD_PARAM: begin
               cmd_next = quad ? ST_DIN : ST_IGN;
            end
            default: begin
               cmd_next = ST_IGN;
            end
         endcase
      end
   end

   // ****************************************
   // read parameters and outgoing byte
   // ****************************************
   always_comb begin
      case (param_ff[5:4])
         2'h2: wrap_dum = 4'h6;
         2'h3: wrap_dum = 4'h8;
         default: wrap_dum = 4'h4;
      endcase
      case (param_ff[1:0])
         2'h0: wmask = 6'h07;
         2'h1: wmask = 6'h0f;
         2'h2: wmask = 6'h1f;
         default: wmask = 6'h3f;
      endcase
   end

   assign ubase = FSR_UID_TOP - {rptr_ff[3:0], 3'h0};

   always_comb begin
      case (cmd_ff)
         FSR_CMD_UID: begin
            src = UID[ubase +: 8];
            nxt_rptr = {rptr_ff[23:4], rptr_ff[3:0] + 4'h1};
         end
         FSR_CMD_READ: begin
            src = mem_rd;
            nxt_rptr = {rptr_ff[23:10], rptr_ff[9:0] + 10'h001};
         end
         default: begin
            src = i_arr_data;
            nxt_rptr = {rptr_ff[23:6],
               (rptr_ff[5:0] & ~wmask) | ((rptr_ff[5:0] + 6'h01) & wmask)};
         end
      endcase
   end

   // ****************************************
   // serial engine
   // ****************************************
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= ST_IGN;
         cmd_ff <= 8'h00;
         in_ff <= 8'h00;
         addr_ff <= 24'h000000;
         rptr_ff <= 24'h000000;
         cnt_ff <= 6'h00;
         dum_ff <= 4'h0;
         ocnt_ff <= 3'h0;
         osr_ff <= 8'h00;
         dq_ff <= 4'h0;
         oe_ff <= 4'h0;
         got_ff <= 1'b0;
         pidx_ff <= 8'h00;
         pvalid_ff <= '0;
      end else if (f_start) begin
         st_ff <= ST_CMD;
         cnt_ff <= 6'h00;
         ocnt_ff <= 3'h0;
         got_ff <= 1'b0;
         oe_ff <= 4'h0;
      end else if (f_end) begin
         oe_ff <= 4'h0;
      end else if (rise) begin
         in_ff <= nxt_in;
         cnt_ff <= nxt_cnt;
         case (st_ff)
            ST_CMD: begin
               if (nxt_cnt == FSR_BITS_CMD) begin
                  cmd_ff <= nxt_in;
                  st_ff <= cmd_next;
                  cnt_ff <= 6'h00;
                  if (cmd_next == ST_ADDR && nxt_in == FSR_CMD_PROG) begin
                     pvalid_ff <= '0;
                  end
               end
            end
            ST_ADDR: begin
               addr_ff <= nxt_addr;
               if (nxt_cnt == FSR_BITS_ADDR) begin
                  cnt_ff <= 6'h00;
                  rptr_ff <= (cmd_ff == FSR_CMD_UID) ? 24'h000000 : nxt_addr;
                  pidx_ff <= nxt_addr[7:0];
                  dum_ff <= (cmd_ff == FSR_CMD_WRAP) ? wrap_dum :
                     (quad ? FSR_DUMMY_QUAD : FSR_DUMMY_SPI);
                  case (cmd_ff)
                     FSR_CMD_ERASE: st_ff <= ST_TAIL;
                     FSR_CMD_PROG: st_ff <= ST_DIN;
                     FSR_CMD_READ: st_ff <= fsr_rgn_ok(nxt_addr) ? ST_DUMMY : ST_IGN;
                     default: st_ff <= ST_DUMMY;
                  endcase
               end
            end
            ST_DUMMY: begin
               cnt_ff <= cnt_ff + 6'h01;
               if (cnt_ff + 6'h01 == {2'h0, dum_ff}) begin
                  st_ff <= ST_DOUT;
               end
            end
            ST_DIN: begin
               if (nxt_cnt == FSR_BITS_CMD) begin
                  cnt_ff <= 6'h00;
                  if (cmd_ff == FSR_CMD_PROG) begin
                     got_ff <= 1'b1;
                     pvalid_ff[pidx_ff] <= 1'b1;
                     pidx_ff <= pidx_ff + 8'h01;
                  end
               end
            end
            ST_TAIL: begin
               st_ff <= ST_IGN;
            end
            default: begin
               cnt_ff <= 6'h00;
            end
         endcase
      end else if (fall && st_ff == ST_DOUT) begin
         ocnt_ff <= ocnt_ff + step[2:0];
         oe_ff <= quad ? 4'hf : 4'h2;
         if (ocnt_ff == 3'h0) begin
            dq_ff <= quad ? src[7:4] : {2'h0, src[7], 1'b0};
            osr_ff <= quad ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
            rptr_ff <= nxt_rptr;
         end else begin
            dq_ff <= quad ? osr_ff[7:4] : {2'h0, osr_ff[7], 1'b0};
            osr_ff <= quad ? {osr_ff[3:0], 4'h0} : {osr_ff[6:0], 1'b0};
         end
      end
   end

   // page buffer has no reset; pvalid_ff guards it
   always_ff @(posedge i_mclk) begin
      if (rise && st_ff == ST_DIN && cmd_ff == FSR_CMD_PROG && nxt_cnt == FSR_BITS_CMD) begin
         pbuf[pidx_ff] <= nxt_in;
      end
   end

   // ****************************************
   // frame-end decisions
   // ****************************************
   assign lock_v = {i_region3_lock_bit, i_region2_lock_bit, i_region1_lock_bit};
   assign locked = lock_v[addr_ff[13:12] - 2'h1];
   assign ers_go = st_ff == ST_TAIL && cmd_ff == FSR_CMD_ERASE && i_write_latch_flag &&
      fsr_rgn_ok(addr_ff) && !locked && op_ff == OP_IDLE;
   assign prg_go = st_ff == ST_DIN && cmd_ff == FSR_CMD_PROG && got_ff &&
      i_write_latch_flag && fsr_rgn_ok(addr_ff) && !locked && op_ff == OP_IDLE;
   assign rst_go = st_ff == ST_TAIL && cmd_ff == FSR_CMD_RST && armed_ff && !rec_ff;
   assign arm_hit = st_ff == ST_TAIL && cmd_ff == FSR_CMD_ARM && !rec_ff;
   assign par_ld = rise && st_ff == ST_DIN && cmd_ff == FSR_CMD_PARAM &&
      nxt_cnt == FSR_BITS_CMD;

   // ****************************************
   // self-timed operations
   // ****************************************
   assign wdone = (op_ff == OP_ERASE) ? (widx_ff == 11'(FSR_REGION_BYTES)) :
      (widx_ff == 11'(FSR_PAGE_BYTES));

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         op_ff <= OP_IDLE;
         busy_ff <= 1'b0;
         rec_ff <= 1'b0;
         armed_ff <= 1'b0;
         clr_wel_ff <= 1'b0;
         srst_ff <= 1'b0;
         param_ff <= FSR_PARAM_RST;
         tmr_ff <= 24'h000000;
         widx_ff <= 11'h000;
         ors_ff <= 2'h0;
         opg_ff <= 2'h0;
      end else begin
         clr_wel_ff <= 1'b0;
         srst_ff <= 1'b0;
         if (par_ld) begin
            param_ff <= nxt_in;
         end
         if (f_end) begin
            armed_ff <= arm_hit;
         end
         if (f_end && rst_go) begin
            op_ff <= OP_RST;
            busy_ff <= 1'b0;
            rec_ff <= 1'b1;
            srst_ff <= 1'b1;
            param_ff <= FSR_PARAM_RST;
            tmr_ff <= 24'h000000;
            armed_ff <= 1'b0;
         end else begin
            case (op_ff)
               OP_IDLE: begin
                  tmr_ff <= 24'h000000;
                  widx_ff <= 11'h000;
                  ors_ff <= addr_ff[13:12] - 2'h1;
                  opg_ff <= addr_ff[9:8];
                  if (f_end && (ers_go || prg_go)) begin
                     op_ff <= ers_go ? OP_ERASE : OP_PROG;
                     busy_ff <= 1'b1;
                     clr_wel_ff <= 1'b1;
                  end
               end
               OP_ERASE, OP_PROG: begin
                  tmr_ff <= tmr_ff + 24'h000001;
                  if (!wdone) begin
                     widx_ff <= widx_ff + 11'h001;
                  end
                  if (wdone && tmr_ff >= 24'(((op_ff == OP_ERASE) ? ERASE_CYC : PROG_CYC) - 1)) begin
                     op_ff <= OP_IDLE;
                     busy_ff <= 1'b0;
                  end
               end
               OP_RST: begin
                  tmr_ff <= tmr_ff + 24'h000001;
                  if (tmr_ff >= 24'(RST_CYC - 1)) begin
                     op_ff <= OP_IDLE;
                     rec_ff <= 1'b0;
                  end
               end
               default: begin
                  op_ff <= OP_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************
   // region storage
   // ****************************************
   fsr_region_mem #(
      .DEPTH(3 * FSR_REGION_BYTES),
      .AW(12)
   ) u_mem (
      .i_mclk(i_mclk),
      .i_wr((op_ff == OP_ERASE && !wdone) ||
         (op_ff == OP_PROG && !wdone && pvalid_ff[widx_ff[7:0]])),
      .i_erase(op_ff == OP_ERASE),
      .i_wr_addr(op_ff == OP_ERASE ? {ors_ff, widx_ff[9:0]} :
         {ors_ff, opg_ff, widx_ff[7:0]}),
      .i_wr_data(pbuf[widx_ff[7:0]]),
      .i_rd_addr({rptr_ff[13:12] - 2'h1, rptr_ff[9:0]}),
      .o_rd_data(mem_rd)
   );

   assign o_dq = dq_ff;
   assign o_dq_oe = oe_ff;
   assign o_arr_addr = rptr_ff;
   assign o_busy_flag = busy_ff;
   assign o_clr_write_latch = clr_wel_ff;
   assign o_soft_reset = srst_ff;
   assign o_reset_recovery = rec_ff;
   assign o_read_param_field = param_ff;
endmodule // fsr_seq

`default_nettype wire

// *** fsr_pkg.sv ***
/*
 * Shared constants, types and helpers of the security-region / unique-ID /
 * software-reset / wrapped-read command slice of a serial NOR flash.
 * Assumes a 200 MHz system clock that oversamples the serial bus.
 */
// Behaviour
// - unique ID: cmd, zero address, dummy, 128 bits
// - three 1024-byte regions, erased and programmed separately
// - region erase needs write latch, cmd, address
// - erase only if frame ends after address
// - erase self-timed, busy set, latch cleared
// - locked region ignores erase
// - region chosen by address bits 15:12
// - region program: latch, cmd, address, data bytes
// - four pages; low ten bits give byte
// - locked region ignores program
// - region read: cmd, address, dummy, data out
// - read address increments, wraps at region end
// - reset needs arming frame then reset frame
// - reset aborts operation, clears volatile settings
// - commands refused during reset recovery
// - four-wire wrapped read wraps inside window
// - wrap length and dummy from read parameters
// - param bits 5:4 pick 4, 6, 8 dummies
// - param bits 1:0 pick 8..64 byte wrap
`default_nettype none

package fsr_pkg;
   // ****************************************
   // command codes
   // ****************************************
   localparam logic [7:0] FSR_CMD_UID = 8'h4b;
   localparam logic [7:0] FSR_CMD_ERASE = 8'h44;
   localparam logic [7:0] FSR_CMD_PROG = 8'h42;
   localparam logic [7:0] FSR_CMD_READ = 8'h48;
   localparam logic [7:0] FSR_CMD_ARM = 8'h66;
   localparam logic [7:0] FSR_CMD_RST = 8'h99;
   localparam logic [7:0] FSR_CMD_WRAP = 8'h0c;
   localparam logic [7:0] FSR_CMD_PARAM = 8'hc0;

   // ****************************************
   // layout and values
   // ****************************************
   localparam int FSR_REGION_BYTES = 1024;
   localparam int FSR_PAGE_BYTES = 256;
   localparam logic [7:0] FSR_HI_ZERO = 8'h00;
   localparam logic [1:0] FSR_MID_ZERO = 2'h0;
   localparam logic [3:0] FSR_RGN_FIRST = 4'h1;
   localparam logic [3:0] FSR_RGN_LAST = 4'h3;
   localparam logic [7:0] FSR_ERASED = 8'hff;
   localparam logic [7:0] FSR_PARAM_RST = 8'h00;
   localparam logic [5:0] FSR_BITS_CMD = 6'h08;
   localparam logic [5:0] FSR_BITS_ADDR = 6'h18;
   localparam logic [3:0] FSR_DUMMY_SPI = 4'h8;
   localparam logic [3:0] FSR_DUMMY_QUAD = 4'h2;
   localparam logic [6:0] FSR_UID_TOP = 7'h78;
   // arbitrary value, stands in for the factory number
   localparam logic [127:0] FSR_UID_DFLT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

   // ****************************************
   // timing
   // ****************************************
   localparam int FSR_CLK_NS = 5;
   localparam int FSR_ERASE_NS = 100000;
   localparam int FSR_PROG_NS = 20000;
   localparam int FSR_RST_NS = 30000;
   localparam int FSR_ERASE_CYC = (FSR_ERASE_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
   localparam int FSR_PROG_CYC = (FSR_PROG_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;
   localparam int FSR_RST_CYC = (FSR_RST_NS + FSR_CLK_NS - 1) / FSR_CLK_NS;

   typedef enum logic [2:0] {
      ST_CMD = 3'h0, ST_ADDR = 3'h1, ST_DUMMY = 3'h2, ST_DIN = 3'h3,
      ST_DOUT = 3'h4, ST_TAIL = 3'h5, ST_IGN = 3'h6
   } fsr_ser_e;

   typedef enum logic [1:0] {
      OP_IDLE = 2'h0, OP_ERASE = 2'h1, OP_PROG = 2'h2, OP_RST = 2'h3
   } fsr_op_e;

   function automatic logic fsr_rgn_ok(input logic [23:0] a);
      return a[23:16] == FSR_HI_ZERO && a[15:12] >= FSR_RGN_FIRST &&
         a[15:12] <= FSR_RGN_LAST && a[11:10] == FSR_MID_ZERO;
   endfunction
endpackage

`default_nettype wire

// *** fsr_sync2.sv ***
/*
 * Two-flop synchroniser for a group of bus pins.
 * Assumes the bits are sampled independently; no bus coherence.
 */
`default_nettype none

module fsr_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end else begin
         meta_ff <= i_d;
         q_ff <= meta_ff;
      end
   end

   assign o_q = q_ff;
endmodule // fsr_sync2

`default_nettype wire

// *** fsr_region_mem.sv ***
/*
 * Storage of the three security regions, one flat byte array.
 * Assumes one write per cycle; program can only clear bits.
 */
`default_nettype none

module fsr_region_mem #(
   parameter int DEPTH = 3072,
   parameter int AW = 12
) (
   input wire logic i_mclk,
   input wire logic i_wr,
   input wire logic i_erase,
   input wire logic [AW-1:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic [AW-1:0] i_rd_addr,
   output logic [7:0] o_rd_data
);
   logic [7:0] mem [DEPTH];
   logic [7:0] rd_ff;

   // flash program only pulls bits low, hence the and
   always_ff @(posedge i_mclk) begin
      if (i_wr) begin
         mem[i_wr_addr] <= i_erase ? 8'hff : (mem[i_wr_addr] & i_wr_data);
      end
      rd_ff <= mem[i_rd_addr];
   end

   assign o_rd_data = rd_ff;
endmodule // fsr_region_mem

`default_nettype wire

// *** fsr_seq_checker.sv ***
/*
 * Port-level checker for the security-region / reset command sequencer.
 * Assumes the bench holds write latch and command mode steady inside frames.
 */
`default_nettype none

module fsr_seq_checker #(
   parameter int ERASE_CYC = 1100,
   parameter int PROG_CYC = 300,
   parameter int RST_CYC = 400
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_four_wire_command_mode,
   input wire logic i_write_latch_flag,
   input wire logic [3:0] o_dq_oe,
   input wire logic o_busy_flag,
   input wire logic o_clr_write_latch,
   input wire logic o_soft_reset,
   input wire logic o_reset_recovery,
   input wire logic [7:0] o_read_param_field
);
   // ****************************************
   // helper counters
   // ****************************************
   int busy_cnt_ff;
   int rec_cnt_ff;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst || !o_busy_flag) begin
         busy_cnt_ff <= 0;
      end else begin
         busy_cnt_ff <= busy_cnt_ff + 1;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst || !o_reset_recovery) begin
         rec_cnt_ff <= 0;
      end else begin
         rec_cnt_ff <= rec_cnt_ff + 1;
      end
   end

   // ****************************************
   // properties
   // ****************************************
   sequence s_rst_state;
      o_reset_recovery && !o_busy_flag && o_read_param_field == 8'h00;
   endsequence
   sequence s_busy_start;
      ##[0:1] o_busy_flag;
   endsequence

   busy_needs_latch_a: assert property ($rose(o_busy_flag) |-> $past(i_write_latch_flag))
      else $error("busy rose without write latch");
   busy_after_cs_a: assert property ($rose(o_busy_flag) |-> i_cs_n)
      else $error("busy rose inside a frame");
   clr_with_busy_a: assert property (o_clr_write_latch |-> s_busy_start)
      else $error("latch clear without busy");
   clr_pulse_one_a: assert property (o_clr_write_latch |=> !o_clr_write_latch)
      else $error("latch clear longer than one cycle");
   busy_length_a: assert property ($fell(o_busy_flag) && !o_soft_reset && !$past(o_soft_reset)
      |-> busy_cnt_ff >= PROG_CYC - 1 && busy_cnt_ff <= ERASE_CYC + 1024)
      else $error("busy length out of range");
   reset_effect_a: assert property (o_soft_reset |-> ##[0:1] s_rst_state)
      else $error("reset did not clear state");
   reset_cs_high_a: assert property (o_soft_reset |-> i_cs_n)
      else $error("reset acted inside a frame");
   recovery_len_a: assert property ($fell(o_reset_recovery)
      |-> rec_cnt_ff >= RST_CYC - 1 && rec_cnt_ff <= RST_CYC + 1)
      else $error("recovery length wrong");
   recovery_quiet_a: assert property (o_reset_recovery |-> !$rose(o_busy_flag))
      else $error("operation started during recovery");
   oe_idle_a: assert property (i_cs_n [*8] |-> o_dq_oe == 4'h0)
      else $error("output driven while deselected");
   oe_mode_a: assert property (o_dq_oe == 4'h0 ||
      o_dq_oe == (i_four_wire_command_mode ? 4'hf : 4'h2))
      else $error("output enable does not match mode");
endmodule // fsr_seq_checker

bind fsr_seq fsr_seq_checker #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC), .RST_CYC(RST_CYC))
   chk_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n),
   .i_four_wire_command_mode(i_four_wire_command_mode),
   .i_write_latch_flag(i_write_latch_flag), .o_dq_oe(o_dq_oe), .o_busy_flag(o_busy_flag),
   .o_clr_write_latch(o_clr_write_latch), .o_soft_reset(o_soft_reset),
   .o_reset_recovery(o_reset_recovery), .o_read_param_field(o_read_param_field));

`default_nettype wire

// *** fsr_host.sv ***
/*
 * Behavioural host controller: drives chip select, serial clock and data.
 * Assumes i_dq is the resolved wire level of the data pins.
 */
`default_nettype none

module fsr_host (
   output var logic o_cs_n,
   output var logic o_sclk,
   output var logic [3:0] o_dq,
   input wire logic [3:0] i_dq
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_dq = 4'h0;
   end

   // ****************************************
   // one chip-select frame, msb first
   // ****************************************
   // clock stands low outside frames; released lines toggle so no stale value shows
   task automatic frame(input logic [63:0] tx, input int ntx, input int nrd, input int w,
      output logic [127:0] rx);
      int k;
      rx = '0;
      o_cs_n = 1'b0;
      for (k = 0; k < ntx + nrd; k += w) begin
         if (k < ntx) begin
            o_dq = (w == 4) ? tx[63 - k -: 4] : {~o_dq[3:1], tx[63 - k]};
         end else begin
            o_dq = ~o_dq;
         end
         #32 o_sclk = 1'b1;
         if (k >= ntx) begin
            rx = (w == 4) ? {rx[123:0], i_dq} : {rx[126:0], i_dq[1]};
         end
         #32 o_sclk = 1'b0;
      end
      #32 o_cs_n = 1'b1;
      #100;
   endtask
endmodule // fsr_host

`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench of the command sequencer with a host model.
 * Assumes shortened erase, program and recovery counts set below.
 */
`default_nettype none

module tb_top
   import fsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // arbitrary value, stands in for the factory number
   localparam logic [127:0] UID_TB = 128'h9e37_79b9_7f4a_7c15_f39c_c060_5ced_c834;
   logic mclk = 1'b0, rst = 1'b1, mode = 1'b0, latch = 1'b0, cs_n, sclk, busy, clr, srst, rec;
   logic [2:0] lk = 3'h0;
   logic [3:0] hdq, odq, oe, wdq;
   logic [7:0] param, rnd, p;
   logic [23:0] aaddr;
   logic [127:0] rx, got_v;
   logic [127:0] exp_q[$];
   string name_q[$];
   event got_ev;
   int err_total = 0, checks_done = 0, cyc = 0, i, k, wl, dm;
   logic seen;
   logic [63:0] tx_a[11];
   int n_a[11];
   logic [2:0] fl_a[11];
   logic [7:0] pr_a[4] = '{8'h00, 8'h12, 8'h21, 8'h33};

   always #2.5 mclk = ~mclk;
   assign wdq = (odq & oe) | (hdq & ~oe);

   fsr_seq #(.ERASE_CYC(1100), .PROG_CYC(300), .RST_CYC(400), .UID(UID_TB)) dut_u (
      .i_mclk(mclk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_dq(wdq), .o_dq(odq),
      .o_dq_oe(oe), .i_four_wire_command_mode(mode), .i_write_latch_flag(latch),
      .i_region1_lock_bit(lk[0]), .i_region2_lock_bit(lk[1]), .i_region3_lock_bit(lk[2]),
      .i_arr_data(aaddr[7:0] + 8'h30), .o_arr_addr(aaddr), .o_busy_flag(busy),
      .o_clr_write_latch(clr), .o_soft_reset(srst), .o_reset_recovery(rec),
      .o_read_param_field(param));
   fsr_host host_u (.o_cs_n(cs_n), .o_sclk(sclk), .o_dq(hdq), .i_dq(wdq));

   // ****************************************
   // result watcher and report
   // ****************************************
   task automatic res(input string n, input logic [127:0] e, input logic [127:0] g);
      exp_q.push_back(e);
      name_q.push_back(n);
      got_v = g;
      ->got_ev;
      #1;
   endtask

   always begin
      @(got_ev);
      checks_done++;
      if (got_v !== exp_q[0]) begin
         $display("wrong value %s expected %h seen %h", name_q[0], exp_q[0], got_v);
         err_total++;
      end
      void'(exp_q.pop_front());
      void'(name_q.pop_front());
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // budget well above a run of about 14000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         final_report();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rnd = 8'($urandom(32'hfe97));
      rnd = 8'($urandom());
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (8) @(posedge mclk);
      host_u.frame({FSR_CMD_UID, 56'h0}, 40, 128, 1, rx);
      res("uid", UID_TB, rx);
      $display("test uid done");
      tx_a = '{{FSR_CMD_ERASE, 24'h001000, 32'h0}, {FSR_CMD_ERASE, 24'h002000, 32'h0},
         {FSR_CMD_ERASE, 24'h003000, 32'h0}, {FSR_CMD_ERASE, 24'h003000, 32'h0},
         {FSR_CMD_ERASE, 24'h001400, 32'h0}, {FSR_CMD_ERASE, 24'h011000, 32'h0},
         {FSR_CMD_ERASE, 24'h003000, 32'h0}, {FSR_CMD_PROG, 24'h0013ff, rnd, 24'h0},
         {FSR_CMD_PROG, 24'h001000, 8'h5a, 24'h0}, {FSR_CMD_PROG, 24'h002000, 32'h0},
         {FSR_CMD_PROG, 24'h001100, 32'h0}};
      n_a = '{32, 32, 33, 32, 32, 32, 32, 40, 40, 40, 39};
      fl_a = '{3'h5, 3'h6, 3'h4, 3'h0, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5, 3'h6, 3'h4};
      for (i = 0; i < 11; i++) begin
         @(posedge mclk) #1;
         latch = fl_a[i][2];
         lk[1] = fl_a[i][1];
         host_u.frame(tx_a[i], n_a[i], 0, 1, rx);
         seen = 1'b0;
         repeat (20) @(posedge mclk) seen = seen | (busy === 1'b1);
         res("busy", fl_a[i][0], seen);
         for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge mclk);
      end
      $display("test erase and program done");
      host_u.frame({FSR_CMD_READ, 24'h0013ff, 32'h0}, 40, 16, 1, rx);
      res("read_wrap", {rnd, 8'h5a}, rx);
      host_u.frame({FSR_CMD_READ, 24'h003200, 32'h0}, 40, 8, 1, rx);
      res("read_erased", FSR_ERASED, rx);
      $display("test region read done");
      @(posedge mclk) #1 mode = 1'b1;
      for (i = 0; i < 4; i++) begin
         p = pr_a[i];
         wl = 8 << p[1:0];
         dm = (p[5:4] == 2'h3) ? 8 : (p[5:4] == 2'h2) ? 6 : 4;
         host_u.frame({FSR_CMD_PARAM, p, 48'h0}, 16, 0, 4, rx);
         res("param", p, param);
         host_u.frame({FSR_CMD_WRAP, 24'(wl - 2), 32'h0}, 32 + dm * 4, 32, 4, rx);
         res("wrap", {8'(wl + 46), 8'(wl + 47), 8'h30, 8'h31}, rx);
      end
      $display("test wrapped read done");
      host_u.frame({FSR_CMD_RST, 56'h0}, 8, 0, 4, rx);
      host_u.frame({FSR_CMD_ARM, 56'h0}, 8, 0, 4, rx);
      host_u.frame({FSR_CMD_READ, 56'h0}, 8, 0, 4, rx);
      host_u.frame({FSR_CMD_RST, 56'h0}, 8, 0, 4, rx);
      res("recovery", 1'b0, rec);
      host_u.frame({FSR_CMD_ERASE, 24'h003000, 32'h0}, 32, 0, 4, rx);
      res("busy", 1'b1, busy);
      host_u.frame({FSR_CMD_ARM, 56'h0}, 8, 0, 4, rx);
      host_u.frame({FSR_CMD_RST, 56'h0}, 8, 0, 4, rx);
      res("busy", 1'b0, busy);
      res("recovery", 1'b1, rec);
      res("param", FSR_PARAM_RST, param);
      host_u.frame({FSR_CMD_ERASE, 24'h003000, 32'h0}, 32, 0, 4, rx);
      res("busy", 1'b0, busy);
      $display("test reset done");
      final_report();
   end
endmodule // tb_top

`default_nettype wire
